// >>> pkg/kdc_pkg.sv
/*
  kdc_pkg: register offsets, reset values, field layout and timing
  constants for the keyscan debounce / interrupt configuration block.
  Assumes a 100 MHz core clock.
*/
package kdc_pkg;
  localparam logic [7:0]  OFS_DEBOUNCE    = 8'h02;
  localparam logic [7:0]  OFS_IRQ_POLICY  = 8'h03;
  localparam logic [7:0]  OFS_PORTS       = 8'h04;
  localparam logic [7:0]  RST_DEBOUNCE    = 8'hFF;
  localparam logic [7:0]  RST_IRQ_POLICY  = 8'h00;
  localparam logic [7:0]  RST_PORTS       = 8'hFE;
  localparam int          PORTS_IRQ_BIT   = 1;
  localparam int          DEB_BASE_MS     = 9;
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          CYC_PER_MS      = CLK_HZ / 1000;
  localparam int          FIFO_CNT_W      = 5;
endpackage

// >>> hw/kdc_ms_tick.sv
/*
  kdc_ms_tick: divides the core clock to a one-cycle millisecond enable.
  Assumes a single clock domain and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module kdc_ms_tick #(
  parameter int DIV = kdc_pkg::CYC_PER_MS
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      ms_tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;

  always_comb begin
    next_cnt = (cnt == 32'(DIV - 1)) ? 32'h0 : cnt + 32'h1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 32'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign ms_tick = (cnt == 32'(DIV - 1));
endmodule // kdc_ms_tick

// >>> hw/kdc_config.sv
/*
  kdc_config: debounce period generator, column output allocation and
  key-event interrupt generation from three 8-bit configuration registers.
  Assumes a register port (address, write strobe, data) from the serial
  bus decoder on the same clock, and an event count from the FIFO logic.
*/
// Notes on behaviour
// - debounce period is 9 ms plus code ms, code 0..31.
// - output-select zero keeps all columns as key-scan columns.
// - codes 1..5 turn columns 7, 7-6, 7-5, 7-4, 7-3 into outputs.
// - upper two select bits set makes columns 7 down to 2 outputs.
// - time code 1 asserts interrupt at end of every debounce cycle.
// - time code N asserts every N debounce cycles; zero disables it.
// - FIFO code C asserts at 2C+2 queued events, code 7 at 14; zero disables it.
// - both nonzero fields apply both triggers together.
// - as plain output, port bit low pulls pin low, one releases it.
`timescale 1ns/1ps
module kdc_config #(
  parameter int MS_DIV = kdc_pkg::CYC_PER_MS
) (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic [7:0]                   reg_wdata,
  output logic      [7:0]                   reg_rdata,
  input  wire logic [kdc_pkg::FIFO_CNT_W-1:0] fifo_count,
  input  wire logic                         irq_clear,
  output logic                              debounce_end,
  output logic      [7:0]                   general_output_line_en,
  output logic                              key_event_irq_pin_o,
  output logic                              key_event_irq_pin_oe
);
  // ==========================================================
  // registers
  logic [7:0] deb_reg;
  logic [7:0] pol_reg;
  logic [7:0] port_reg;
  logic [7:0] next_deb_reg;
  logic [7:0] next_pol_reg;
  logic [7:0] next_port_reg;

  always_comb begin
    next_deb_reg  = deb_reg;
    next_pol_reg  = pol_reg;
    next_port_reg = port_reg;
    if (reg_wr) begin
      case (reg_addr)
        kdc_pkg::OFS_DEBOUNCE:   next_deb_reg  = reg_wdata;
        kdc_pkg::OFS_IRQ_POLICY: next_pol_reg  = reg_wdata;
        kdc_pkg::OFS_PORTS:      next_port_reg = {reg_wdata[7:1], 1'b0};
        default:                 next_deb_reg  = deb_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deb_reg  <= kdc_pkg::RST_DEBOUNCE;
      pol_reg  <= kdc_pkg::RST_IRQ_POLICY;
      port_reg <= kdc_pkg::RST_PORTS;
    end else begin
      deb_reg  <= next_deb_reg;
      pol_reg  <= next_pol_reg;
      port_reg <= next_port_reg;
    end
  end

  always_comb begin
    case (reg_addr)
      kdc_pkg::OFS_DEBOUNCE:   reg_rdata = deb_reg;
      kdc_pkg::OFS_IRQ_POLICY: reg_rdata = pol_reg;
      kdc_pkg::OFS_PORTS:      reg_rdata = port_reg;
      default:                 reg_rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // column output allocation
  function automatic logic [7:0] col_mask(input logic [2:0] sel);
    case (sel)
      3'h0:    col_mask = 8'h00;
      3'h1:    col_mask = 8'h80;
      3'h2:    col_mask = 8'hC0;
      3'h3:    col_mask = 8'hE0;
      3'h4:    col_mask = 8'hF0;
      3'h5:    col_mask = 8'hF8;
      default: col_mask = 8'hFC;
    endcase
  endfunction

  logic [7:0] next_gol;
  always_comb begin
    next_gol = col_mask(deb_reg[7:5]);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      general_output_line_en <= 8'h00;
    end else begin
      general_output_line_en <= next_gol;
    end
  end

  // ==========================================================
  // debounce period
  logic       ms_tick;
  logic [5:0] ms_cnt;
  logic [5:0] next_ms_cnt;
  logic       deb_done;

  kdc_ms_tick #(.DIV(MS_DIV)) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .ms_tick (ms_tick)
  );

  // period ends after 9 + code milliseconds
  assign deb_done = ms_tick &&
    (ms_cnt == 6'(kdc_pkg::DEB_BASE_MS - 1) + {1'b0, deb_reg[4:0]});

  always_comb begin
    next_ms_cnt = ms_cnt;
    if (deb_done) begin
      next_ms_cnt = 6'h00;
    end else if (ms_tick) begin
      next_ms_cnt = ms_cnt + 6'h01;
    end
  end

  // ==========================================================
  // interrupt generation
  logic [4:0] per_cnt;
  logic [4:0] next_per_cnt;
  logic       irq;
  logic       next_irq;
  logic       next_deb_end;
  logic       time_hit;
  logic       fifo_hit;
  logic       fifo_lvl_d;
  logic       fifo_lvl;

  localparam int FIFO_W = kdc_pkg::FIFO_CNT_W;

  // level 2C+2, code 7 tops out at 14 events
  function automatic logic [FIFO_W-1:0] fifo_thr(input logic [2:0] code);
    if (code == 3'h7) begin
      fifo_thr = FIFO_W'(8'h0E);
    end else begin
      fifo_thr = FIFO_W'({code, 1'b0}) + FIFO_W'(8'h02);
    end
  endfunction

  assign fifo_lvl = (pol_reg[7:5] != 3'h0) &&
    (fifo_count >= fifo_thr(pol_reg[7:5]));

  assign time_hit = deb_done && (pol_reg[4:0] != 5'h00) &&
                    (per_cnt + 5'h01 >= pol_reg[4:0]);
  assign fifo_hit = fifo_lvl && !fifo_lvl_d;

  always_comb begin
    next_per_cnt = per_cnt;
    if (pol_reg[4:0] == 5'h00 || time_hit) begin
      next_per_cnt = 5'h00;
    end else if (deb_done) begin
      next_per_cnt = per_cnt + 5'h01;
    end
    next_irq = irq;
    if (irq_clear) begin
      next_irq = 1'b0;
    end
    if (time_hit || fifo_hit) begin
      next_irq = 1'b1;
    end
    if (pol_reg == 8'h00) begin
      next_irq = 1'b0;
    end
    next_deb_end = deb_done;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt       <= 6'h00;
      per_cnt      <= 5'h00;
      irq          <= 1'b0;
      fifo_lvl_d   <= 1'b0;
      debounce_end <= 1'b0;
    end else begin
      ms_cnt       <= next_ms_cnt;
      per_cnt      <= next_per_cnt;
      irq          <= next_irq;
      fifo_lvl_d   <= fifo_lvl;
      debounce_end <= next_deb_end;
    end
  end

  // ==========================================================
  // pin drive: open drain, low when asserted, or when port bit low with policy register zero
  assign key_event_irq_pin_o  = 1'b0;
  assign key_event_irq_pin_oe = (pol_reg == 8'h00) ?
    !port_reg[kdc_pkg::PORTS_IRQ_BIT] : irq;

  // ==========================================================
  // assertions
  sequence s_deb_end;
    deb_done;
  endsequence

  a_col_zero_sel: assert property (
    @(posedge clk) disable iff (!reset_n)
    (deb_reg[7:5] == 3'h0) |=> general_output_line_en == 8'h00)
    else $error("columns used as outputs with zero select");
  a_col_cumul: assert property (
    @(posedge clk) disable iff (!reset_n)
    (deb_reg[7:5] == 3'h3) |=> general_output_line_en == 8'hE0)
    else $error("select 3 did not give columns 7 to 5");
  a_col_six: assert property (
    @(posedge clk) disable iff (!reset_n)
    (deb_reg[7:6] == 2'h3) |=> general_output_line_en == 8'hFC)
    else $error("top select did not give six outputs");
  a_deb_length: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_deb_end |-> ms_cnt == 6'(kdc_pkg::DEB_BASE_MS - 1)
      + {1'b0, deb_reg[4:0]})
    else $error("debounce period length wrong");
  a_time_every: assert property (
    @(posedge clk) disable iff (!reset_n)
    (s_deb_end and pol_reg == 8'h01 and !irq_clear) |=> irq)
    else $error("interrupt missed at debounce end");
  a_time_off: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pol_reg[4:0] == 5'h00 && !fifo_hit && !irq) |=> !irq)
    else $error("time trigger while disabled");
  a_fifo_level: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pol_reg == 8'h20 && fifo_count == 5'h04 && !fifo_lvl_d
     && !irq_clear) |=> irq)
    else $error("fifo level 4 did not interrupt");
  a_fifo_top: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pol_reg == 8'hE0 && fifo_count == 5'h0E && !fifo_lvl_d
     && !irq_clear) |=> irq)
    else $error("fifo level 14 did not interrupt");
  a_both_trig: assert property (
    @(posedge clk) disable iff (!reset_n)
    (fifo_hit && pol_reg[4:0] != 5'h00 && !irq_clear) |=> irq)
    else $error("fifo trigger lost with both enabled");
  a_gpo_pin: assert property (
    @(posedge clk) disable iff (!reset_n)
    (pol_reg == 8'h00) |-> (key_event_irq_pin_oe
      == !port_reg[kdc_pkg::PORTS_IRQ_BIT]) ##1 !irq)
    else $error("pin not following port bit");
endmodule // kdc_config

// >>> tb/kdc_host_bfm.sv
/*
  kdc_host_bfm: host side, writes config registers, sources event count.
  Assumes the bench calls its tasks; drives on the falling clock edge.
*/
`timescale 1ns/1ps
module kdc_host_bfm (
  input  wire logic clk,
  output logic [7:0] reg_addr   = 8'h00,
  output logic       reg_wr     = 1'b0,
  output logic [7:0] reg_wdata  = 8'h00,
  output logic [4:0] fifo_count = 5'h00,
  output logic       irq_clear  = 1'b0
);
  // ==================================================
  // host tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic ad(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
  endtask
  // caller sits on a falling edge
  task automatic cnt(input logic [4:0] c);
    fifo_count = c;
  endtask
  task automatic clr();
    @(negedge clk);
    irq_clear = 1'b1;
    @(negedge clk);
    irq_clear = 1'b0;
  endtask
endmodule // kdc_host_bfm

// >>> tb/tb_top.sv
/*
  tb_top: self-checking bench for kdc_config with a short ms divider.
  Assumes kdc_host_bfm drives the register side.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] a, wd, rd, col;
  logic [4:0] fc;
  logic wr, clr, dend, po, oe;
  int err_total = 0;
  int cmp_count = 0;
  int n, k;
  initial forever #5 clk = ~clk;
  kdc_host_bfm u_host (.clk(clk), .reg_addr(a), .reg_wr(wr),
    .reg_wdata(wd), .fifo_count(fc), .irq_clear(clr));
  kdc_config #(.MS_DIV(10)) u_dut (.clk(clk), .reset_n(reset_n),
    .reg_addr(a), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rd),
    .fifo_count(fc), .irq_clear(clr), .debounce_end(dend),
    .general_output_line_en(col), .key_event_irq_pin_o(po),
    .key_event_irq_pin_oe(oe));
  // ==================================================
  // helpers
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic gap();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (dend !== 1'b1 && n < 1000);
    if (n >= 1000) err_total++;
  endtask
  task automatic rdc(logic [7:0] ad, logic [7:0] e);
    u_host.ad(ad);
    #1 chk("rdata", {8'h00, e}, {8'h00, rd});
  endtask
  // ==================================================
  // scenarios
  task automatic t_cols();
    logic [7:0] tbl[8] = '{8'h00, 8'h80, 8'hC0, 8'hE0,
                           8'hF0, 8'hF8, 8'hFC, 8'hFC};
    for (int i = 0; i < 8; i++) begin
      u_host.wr(8'h02, {i[2:0], 5'h00});
      repeat (2) @(negedge clk);
      chk("col_en", {8'h00, tbl[i]}, {8'h00, col});
    end
  endtask
  task automatic t_deb();
    u_host.wr(8'h02, 8'h00);
    gap();
    gap();
    chk("period0", 16'h005A, n[15:0]);
    u_host.wr(8'h02, 8'h1F);
    gap();
    gap();
    chk("period31", 16'h0190, n[15:0]);
    u_host.wr(8'h02, 8'h00);
  endtask
  task automatic t_time(logic [7:0] c);
    u_host.wr(8'h03, 8'h00);
    u_host.wr(8'h03, c);
    k = 0;
    do begin
      gap();
      @(negedge clk);
      k++;
    end while (oe !== 1'b1 && k < 40);
    chk("ends", {8'h00, c}, k[15:0]);
  endtask
  task automatic t_fifo(logic [2:0] c, logic [4:0] th);
    u_host.wr(8'h03, 8'h00);
    u_host.cnt(th - 5'h01);
    u_host.wr(8'h03, {c, 5'h00});
    repeat (3) @(negedge clk);
    chk("below", 16'h0000, {15'h0, oe});
    u_host.cnt(th);
    repeat (2) @(negedge clk);
    chk("at", 16'h0001, {15'h0, oe});
    u_host.clr();
    @(negedge clk);
    chk("held", 16'h0000, {15'h0, oe});
    u_host.cnt(5'h00);
  endtask
  task automatic t_both();
    u_host.wr(8'h03, 8'h21);
    gap();
    u_host.clr();
    chk("both_c", 16'h0000, {15'h0, oe});
    u_host.cnt(5'h04);
    repeat (2) @(negedge clk);
    chk("both_f", 16'h0001, {15'h0, oe});
    u_host.cnt(5'h00);
    u_host.clr();
    gap();
    @(negedge clk);
    chk("both_t", 16'h0001, {15'h0, oe});
  endtask
  task automatic t_gpo();
    u_host.wr(8'h03, 8'h00);
    u_host.wr(8'h04, 8'hFC);
    repeat (2) @(negedge clk);
    chk("pin_low", 16'h0001, {15'h0, oe});
    chk("pin_o", 16'h0000, {15'h0, po});
    rdc(8'h04, 8'hFC);
    u_host.wr(8'h04, 8'hFE);
    repeat (2) @(negedge clk);
    chk("pin_rel", 16'h0000, {15'h0, oe});
    u_host.wr(8'h10, 8'hFF);
    rdc(8'h10, 8'h00);
    rdc(8'h02, 8'h00);
  endtask
  // ==================================================
  // main and watchdog
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    rdc(8'h02, 8'hFF);
    rdc(8'h03, 8'h00);
    rdc(8'h04, 8'hFE);
    chk("rst_oe", 16'h0000, {15'h0, oe});
    chk("rst_col", 16'h00FC, {8'h00, col});
    t_cols();
    t_deb();
    t_time(8'h01);
    t_time(8'h03);
    t_fifo(3'h1, 5'h04);
    t_fifo(3'h7, 5'h0E);
    t_both();
    t_gpo();
    print_verdict();
  end
  initial begin
    #300000;
    err_total++;
    print_verdict();
  end
endmodule // tb_top
